// ### logic/acrpc_top.sv
// converter channel, reference and port control: two control registers,
// a successive-approximation result register and analog front-end steering
// assumes a comparator output from the analog front end on this clock
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// Operation
// - each conversion yields a 10-bit result.
// - the small variant has 11 analog inputs, the large one 15.
// - calibrate bit set makes the next conversion calibrate first.
// - control 0 bit 6 and control 1 bits 7..6 always read zero.
// - channel field bits 5..2 routes the channel equal to its code.
// - converting an unimplemented channel returns a random result.
// - channel 12 exists only on the large variant; channels 13 to 15 exist on neither.
// - with the converter on, the status bit reads 1 while converting.
// - the enable bit turns the converter on when 1, off when 0.
// - bit 5 of control 1 picks channel 2 or analog ground as low ref.
// - bit 4 of control 1 picks channel 3 or analog supply as high ref.
// - pin field 0000 makes every pin but pin 5 analog (only pins 0-11 on the small variant) and 1111 all digital.
// - setting the status bit stops sampling and starts a conversion.
// - at completion the result loads, status clears, done flag sets.
// - reset clears the controls, turns off and aborts any conversion.
module acrpc_top
	import acrpc_pkg::*;
#(
	parameter bit LARGE_PKG = 1'b1
)
(
	input  wire logic                       clock,
	input  wire logic                       reset,
	input  wire logic [1:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_write,
	input  wire logic                       reg_read,
	output logic      [7:0]                 reg_rdata,
	input  wire logic                       cmp_in,
	input  wire logic                       flag_clear,
	output logic                            conv_done_flag,
	output logic      [3:0]                 channel_select,
	output logic                            chan_valid,
	output logic                            sample_hold,
	output logic                            calibrating,
	output logic      [ACRPC_RES_W-1:0]     dac_code,
	output logic                            neg_ref_select,
	output logic                            pos_ref_select,
	output logic      [ACRPC_NUM_PINS-1:0]  pin_analog,
	output logic      [ACRPC_RES_W-1:0]     result_pair
);

	logic [7:0]              ctrl0_ff;
	logic [7:0]              ctrl1_ff;
	logic [ACRPC_RES_W-1:0]  sar_ff;
	logic [ACRPC_RES_W-1:0]  mask_ff;
	logic [ACRPC_RES_W-1:0]  result_ff;
	logic [ACRPC_RES_W-1:0]  lfsr_ff;
	logic                    flag_ff;
	logic [7:0]              rdata_ff;
	logic                    cmp_meta_ff;
	logic                    cmp_sync_ff;
	logic [3:0]              chs;
	logic [3:0]              pcfg;
	logic                    converter_on;
	logic                    go_write;
	logic                    chan_impl;
	logic [3:0]              pcfg_eff;
	logic [4:0]              n_analog;
	logic [7:0]              nxt_ctrl0;

	acrpc_seq_if sq ();

	acrpc_seq u_seq (
		.clock (clock),
		.reset (reset),
		.sq    (sq)
	);

	assign chs          = ctrl0_ff[ACRPC_CHS_LSB +: 4];
	assign pcfg         = ctrl1_ff[ACRPC_PCFG_LSB +: 4];
	assign converter_on = ctrl0_ff[ACRPC_ON_BIT];

	// ==================================================================
	// channel decode
	always_comb begin
		chan_impl = (chs != ACRPC_CHS_UNUSED);
		if (LARGE_PKG) begin
			chan_impl = chan_impl && (chs <= ACRPC_CHS_LAST);
		end else begin
			chan_impl = chan_impl && (chs <= ACRPC_CHS_SMALLMAX);
		end
	end

	// ==================================================================
	// register writes
	assign go_write = reg_write && reg_addr == ACRPC_OFF_CTRL0
		&& reg_wdata[ACRPC_GO_BIT] && reg_wdata[ACRPC_ON_BIT]
		&& !sq.busy;

	always_comb begin
		nxt_ctrl0 = ctrl0_ff;
		if (reg_write && reg_addr == ACRPC_OFF_CTRL0) begin
			nxt_ctrl0 = reg_wdata & ACRPC_CTRL0_MASK;
			if (!reg_wdata[ACRPC_ON_BIT]) begin
				nxt_ctrl0[ACRPC_GO_BIT] = 1'b0;
			end else if (sq.busy) begin
				nxt_ctrl0[ACRPC_GO_BIT] = 1'b1;
			end
		end
		if (go_write) begin
			nxt_ctrl0[ACRPC_CAL_BIT] = 1'b0;
		end
		if (sq.done) begin
			nxt_ctrl0[ACRPC_GO_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl0_ff <= ACRPC_CTRL0_RST;
		end else begin
			ctrl0_ff <= nxt_ctrl0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl1_ff <= ACRPC_CTRL1_RST;
		end else if (reg_write && reg_addr == ACRPC_OFF_CTRL1) begin
			ctrl1_ff <= reg_wdata & ACRPC_CTRL1_MASK;
		end
	end

	// ==================================================================
	// sequencer control
	assign sq.start     = go_write;
	assign sq.calibrate = go_write ? reg_wdata[ACRPC_CAL_BIT]
		: ctrl0_ff[ACRPC_CAL_BIT];
	assign sq.abort     = sq.busy && (!converter_on
		|| (reg_write && reg_addr == ACRPC_OFF_CTRL0
		&& !reg_wdata[ACRPC_ON_BIT]));

	// ==================================================================
	// comparator synchroniser
	always_ff @(posedge clock) begin
		cmp_meta_ff <= cmp_in;
		cmp_sync_ff <= cmp_meta_ff;
	end

	// ==================================================================
	// successive approximation
	always_ff @(posedge clock) begin
		if (reset || !sq.busy) begin
			sar_ff  <= {1'b1, {(ACRPC_RES_W-1){1'b0}}};
			mask_ff <= {1'b1, {(ACRPC_RES_W-1){1'b0}}};
		end else if (sq.bit_strobe && mask_ff != '0) begin
			sar_ff <= (sar_ff & ~(cmp_sync_ff ? '0 : mask_ff))
				| (mask_ff >> 1);
			mask_ff <= mask_ff >> 1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			lfsr_ff <= 10'h001;
		end else begin
			lfsr_ff <= {lfsr_ff[8:0], lfsr_ff[9] ^ lfsr_ff[6]};
		end
	end

	// result is not cleared by reset
	always_ff @(posedge clock) begin
		if (sq.done) begin
			result_ff <= chan_impl ? sar_ff : lfsr_ff;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			flag_ff <= 1'b0;
		end else if (sq.done) begin
			flag_ff <= 1'b1;
		end else if (flag_clear) begin
			flag_ff <= 1'b0;
		end
	end

	// ==================================================================
	// pin configuration: code 1010 behaves as 1001
	always_comb begin
		pcfg_eff = (pcfg == 4'hA) ? 4'h9 : pcfg;
		if (pcfg_eff == 4'h0) begin
			n_analog = 5'h10;
		end else if (pcfg_eff >= 4'hA) begin
			n_analog = 5'(5'h10 - {1'b0, pcfg_eff} - 5'h01);
		end else begin
			n_analog = 5'(5'h0F - {1'b0, pcfg_eff});
		end
		if (pcfg_eff == 4'hF) begin
			n_analog = 5'h00;
		end
		for (int i = 0; i < ACRPC_NUM_PINS; i++) begin
			pin_analog[i] = (5'(i) < n_analog)
				&& (LARGE_PKG || i < 12) && i != 5;
		end
	end

	// ==================================================================
	// register reads
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_ff <= 8'h00;
		end else if (reg_read) begin
			unique case (reg_addr)
				ACRPC_OFF_CTRL0: rdata_ff <= ctrl0_ff;
				ACRPC_OFF_CTRL1: rdata_ff <= ctrl1_ff;
				ACRPC_OFF_RESLO: rdata_ff <= result_ff[7:0];
				ACRPC_OFF_RESHI: rdata_ff <= {6'h00, result_ff[9:8]};
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata      = rdata_ff;
	assign conv_done_flag = flag_ff;
	assign channel_select = chs;
	assign chan_valid     = chan_impl;
	assign sample_hold    = sq.sample_hold && converter_on;
	assign calibrating    = sq.calibrating;
	assign dac_code       = sar_ff;
	assign neg_ref_select = ctrl1_ff[ACRPC_NREF_BIT];
	assign pos_ref_select = ctrl1_ff[ACRPC_PREF_BIT];
	assign result_pair    = result_ff;

endmodule

// ### logic/acrpc_pkg.sv
// package for the converter channel, reference and port control block
// constants shared by the control top and its conversion sequencer
package acrpc_pkg;

	// ==================================================================
	// register map (word index on the plain register port)
	localparam logic [1:0] ACRPC_OFF_CTRL0  = 2'h0;
	localparam logic [1:0] ACRPC_OFF_CTRL1  = 2'h1;
	localparam logic [1:0] ACRPC_OFF_RESLO  = 2'h2;
	localparam logic [1:0] ACRPC_OFF_RESHI  = 2'h3;

	// ==================================================================
	// field positions
	localparam int ACRPC_CAL_BIT   = 7;
	localparam int ACRPC_CHS_LSB   = 2;
	localparam int ACRPC_GO_BIT    = 1;
	localparam int ACRPC_ON_BIT    = 0;
	localparam int ACRPC_NREF_BIT  = 5;
	localparam int ACRPC_PREF_BIT  = 4;
	localparam int ACRPC_PCFG_LSB  = 0;

	// ==================================================================
	// reset values and writable masks
	localparam logic [7:0] ACRPC_CTRL0_RST  = 8'h00;
	localparam logic [7:0] ACRPC_CTRL1_RST  = 8'h00;
	localparam logic [7:0] ACRPC_CTRL0_MASK = 8'hBF;
	localparam logic [7:0] ACRPC_CTRL1_MASK = 8'h3F;

	// ==================================================================
	// converter sizes
	localparam int ACRPC_RES_W      = 10;
	localparam int ACRPC_NUM_PINS   = 16;
	localparam logic [3:0] ACRPC_CHS_UNUSED  = 4'h5;
	localparam logic [3:0] ACRPC_CHS_LAST    = 4'hC;
	localparam logic [3:0] ACRPC_CHS_SMALLMAX = 4'hB;

	// ==================================================================
	// timing: one bit time and the bit times per conversion
	localparam int ACRPC_CLK_MHZ    = 250;
	// three cycles per bit time so the two-flop comparator sync settles
	localparam int ACRPC_TBIT_NS    = 12;
	localparam int ACRPC_TBIT_CYC   = (ACRPC_TBIT_NS * ACRPC_CLK_MHZ
		+ 999) / 1000;
	localparam int ACRPC_CONV_BITS  = 11;
	localparam int ACRPC_CAL_BITS   = 11;

	typedef enum logic [1:0] {
		ACRPC_IDLE = 2'b00,
		ACRPC_CAL  = 2'b01,
		ACRPC_CONV = 2'b11
	} acrpc_state_t;

endpackage

// ### logic/acrpc_seq_if.sv
// interface between the control top and the conversion sequencer
// assumes both ends share one clock and reset
`timescale 1ns/1ns
interface acrpc_seq_if;
	logic                         start;
	logic                         calibrate;
	logic                         abort;
	logic                         busy;
	logic                         done;
	logic                         sample_hold;
	logic                         bit_strobe;
	logic                         calibrating;

	modport ctrl (output start, output calibrate, output abort,
		input busy, input done, input sample_hold, input bit_strobe,
		input calibrating);
	modport seq (input start, input calibrate, input abort,
		output busy, output done, output sample_hold,
		output bit_strobe, output calibrating);
endinterface

// ### logic/acrpc_seq.sv
// conversion sequencer: optional calibration pass, then bit times
// assumes start is a one-cycle pulse from the control top
`timescale 1ns/1ns
module acrpc_seq
	import acrpc_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  reset,
	acrpc_seq_if.seq   sq
);

	acrpc_state_t  state_ff;
	logic [7:0]    tick_ff;
	logic [4:0]    bits_ff;
	logic          last_tick;
	logic          last_bit;

	assign last_tick = (tick_ff == 8'(ACRPC_TBIT_CYC - 1));
	assign last_bit  = (state_ff == ACRPC_CAL)
		? (bits_ff == 5'(ACRPC_CAL_BITS - 1))
		: (bits_ff == 5'(ACRPC_CONV_BITS - 1));

	// ==================================================================
	// state
	always_ff @(posedge clock) begin
		if (reset || sq.abort) begin
			state_ff <= ACRPC_IDLE;
		end else begin
			unique case (state_ff)
				ACRPC_IDLE: begin
					if (sq.start) begin
						state_ff <= sq.calibrate ? ACRPC_CAL : ACRPC_CONV;
					end
				end
				ACRPC_CAL: begin
					if (last_tick && last_bit) begin
						state_ff <= ACRPC_CONV;
					end
				end
				ACRPC_CONV: begin
					if (last_tick && last_bit) begin
						state_ff <= ACRPC_IDLE;
					end
				end
				default: state_ff <= ACRPC_IDLE;
			endcase
		end
	end

	// ==================================================================
	// bit-time counters
	always_ff @(posedge clock) begin
		if (reset || sq.abort || state_ff == ACRPC_IDLE) begin
			tick_ff <= 8'h00;
			bits_ff <= 5'h00;
		end else if (last_tick) begin
			tick_ff <= 8'h00;
			bits_ff <= last_bit ? 5'h00 : bits_ff + 5'h01;
		end else begin
			tick_ff <= tick_ff + 8'h01;
		end
	end

	assign sq.busy        = (state_ff != ACRPC_IDLE);
	assign sq.calibrating = (state_ff == ACRPC_CAL);
	assign sq.sample_hold = (state_ff == ACRPC_IDLE);
	assign sq.bit_strobe  = (state_ff == ACRPC_CONV) && last_tick;
	assign sq.done        = (state_ff == ACRPC_CONV) && last_tick
		&& last_bit;

endmodule

// ### testbench/acrpc_properties.sv
// checker of the converter control ports
// assumes a bind onto acrpc_top with the large package variant
`timescale 1ns/1ns
module acrpc_properties (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic [1:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_rdata,
	input wire logic        conv_done_flag,
	input wire logic [3:0]  channel_select,
	input wire logic        chan_valid,
	input wire logic        sample_hold,
	input wire logic        calibrating,
	input wire logic        neg_ref_select,
	input wire logic        pos_ref_select,
	input wire logic [15:0] pin_analog
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// ==================================================================
	// register port
	rdata_idle_a: assert property (
		!reg_read |=> reg_rdata == 8'h00) else $error("stray read data");
	ctrl_rsvd_a: assert property (
		reg_read && !reg_addr[1] |=> !reg_rdata[6]
		&& !(reg_rdata[7] && $past(reg_addr[0])))
		else $error("reserved bit reads one");
	res_high_a: assert property (
		reg_read && reg_addr == 2'h3 |=> reg_rdata[7:2] == 6'h00)
		else $error("result high byte too wide");
	// ==================================================================
	// steering outputs
	chan_wr_a: assert property (
		reg_write && reg_addr == 2'h0 |=>
		channel_select == $past(reg_wdata[5:2]))
		else $error("channel not routed");
	ref_sel_a: assert property (
		reg_write && reg_addr == 2'h1 |=>
		{neg_ref_select, pos_ref_select} == $past(reg_wdata[5:4]))
		else $error("reference select wrong");
	pin_all_a: assert property (
		reg_write && reg_addr == 2'h1 && reg_wdata[3:0] == 4'h0 |=>
		(pin_analog & 16'hFFDF) == 16'hFFDF)
		else $error("pins not all analog");
	chan_impl_a: assert property (
		channel_select > 4'hC |-> !chan_valid)
		else $error("absent channel valid");
	// ==================================================================
	// conversion sequence
	conv_off_a: assert property (
		reg_write && reg_addr == 2'h0 && !reg_wdata[0] |=>
		!sample_hold && !calibrating) else $error("off but active");
	done_idle_a: assert property (
		$rose(conv_done_flag) |-> sample_hold && !calibrating)
		else $error("done while busy");
	done_late_a: assert property (
		$rose(conv_done_flag) |-> $past(sample_hold, 20) == 1'b0)
		else $error("conversion too short");
	cal_hold_a: assert property (
		calibrating |-> !sample_hold) else $error("sampling in cal");
endmodule
bind acrpc_top acrpc_properties u_props (.clock, .reset, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .conv_done_flag,
	.channel_select, .chan_valid, .sample_hold, .calibrating,
	.neg_ref_select, .pos_ref_select, .pin_analog);

// ### testbench/acrpc_front_model.sv
// analog front end: each channel carries a fixed level
// assumes the comparator is read against dac_code on this clock
`timescale 1ns/1ns
module acrpc_front_model
	import acrpc_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic [3:0]             channel_select,
	input  wire logic                   sample_hold,
	input  wire logic [ACRPC_RES_W-1:0] dac_code,
	output logic                        cmp_in
);
	logic [ACRPC_RES_W-1:0] held_ff = '0;
	// track the routed channel while sampling, freeze when converting
	always @(posedge clock) begin
		if (sample_hold) begin
			held_ff <= {channel_select, 6'h2B};
		end
	end
	// input sits half a step above its code
	assign cmp_in = (held_ff >= dac_code);
endmodule

// ### testbench/acrpc_top_tb.sv
// testbench of the converter control top
// assumes the front end model and the bound checker
`timescale 1ns/1ns
module acrpc_top_tb
	import acrpc_pkg::*;
;
	localparam int CONV = ACRPC_CONV_BITS * ACRPC_TBIT_CYC;
	localparam int CALC = ACRPC_CAL_BITS * ACRPC_TBIT_CYC;
	logic        clock, reset, reg_write, reg_read, cmp_in, flag_clear;
	logic [1:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic        conv_done_flag, chan_valid, sample_hold, calibrating;
	logic [3:0]  channel_select;
	logic        neg_ref_select, pos_ref_select;
	logic [9:0]  dac_code, result_pair;
	logic [15:0] pin_analog;
	int          fail_count, tests_run;

	acrpc_top #(.LARGE_PKG(1'b1)) u_dut (.clock(clock), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .cmp_in(cmp_in), .flag_clear(flag_clear),
		.conv_done_flag(conv_done_flag), .channel_select(channel_select),
		.chan_valid(chan_valid), .sample_hold(sample_hold),
		.calibrating(calibrating), .dac_code(dac_code),
		.neg_ref_select(neg_ref_select), .pos_ref_select(pos_ref_select),
		.pin_analog(pin_analog), .result_pair(result_pair));
	acrpc_front_model u_front (.clock(clock),
		.channel_select(channel_select), .sample_hold(sample_hold),
		.dac_code(dac_code), .cmp_in(cmp_in));

	always #2 clock = ~clock;
	// ==================================================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic do_reset(input int n);
		reset <= 1'b1;
		repeat (n) @(posedge clock);
		reset <= 1'b0;
	endtask
	task automatic start(input logic [7:0] c);
		flag_clear <= 1'b1;
		wr(ACRPC_OFF_CTRL0, c & 8'hFD);
		flag_clear <= 1'b0;
		repeat (4) @(posedge clock);
		wr(ACRPC_OFF_CTRL0, c);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==================================================================
	// scenarios
	task automatic t_regs();
		logic [7:0] d;
		rd(ACRPC_OFF_CTRL0, d);
		chk(d, ACRPC_CTRL0_RST);
		rd(ACRPC_OFF_CTRL1, d);
		chk(d, ACRPC_CTRL1_RST);
		wr(ACRPC_OFF_CTRL1, 8'hFF);
		rd(ACRPC_OFF_CTRL1, d);
		chk(d, 8'h3F);
		chk({neg_ref_select, pos_ref_select}, 2'b11);
		wr(ACRPC_OFF_CTRL0, 8'h74);
		rd(ACRPC_OFF_CTRL0, d);
		chk(d, 8'h34);
		chk(chan_valid, 1'b0);
		wr(ACRPC_OFF_CTRL1, 8'h00);
		chk({neg_ref_select, pos_ref_select}, 2'b00);
		$display("test regs done");
	endtask
	task automatic t_pins();
		logic [16:0] e;
		int t;
		for (int c = 0; c < 16; c++) begin
			wr(ACRPC_OFF_CTRL1, 8'(c));
			t = (c == 0) ? 16 : (c == 10) ? 6 : 15 - c;
			e = (17'h1 << t) - 17'h1;
			chk(pin_analog & 16'hFFDF, e[15:0] & 16'hFFDF);
		end
		$display("test pins done");
	endtask
	task automatic t_conv(input logic [3:0] ch, input logic cal);
		logic [7:0] d, lo;
		int n, dur;
		dur = cal ? CONV + CALC : CONV;
		start({cal, 1'b0, ch, 2'b11});
		rd(ACRPC_OFF_CTRL0, d);
		chk(d[1], 1'b1);
		n = 1;
		while (d[1] === 1'b1 && n < 60) begin
			rd(ACRPC_OFF_CTRL0, d);
			n++;
		end
		chk({d[7], d[1]}, 2'b00);
		chk(n * 2 >= dur - 4 && n * 2 <= dur + 6, 1'b1);
		chk(conv_done_flag, 1'b1);
		chk(result_pair, {6'h00, ch, 6'h2B});
		rd(ACRPC_OFF_RESLO, lo);
		rd(ACRPC_OFF_RESHI, d);
		chk({d, lo}, {6'h00, ch, 6'h2B});
		$display("test conversion %0d done", ch);
	endtask
	task automatic t_stop(input logic by_reset);
		logic [7:0] d;
		start(8'h07);
		repeat (4) @(posedge clock);
		if (by_reset)
			do_reset(2);
		else
			wr(ACRPC_OFF_CTRL0, 8'h04);
		rd(ACRPC_OFF_CTRL0, d);
		chk(d, by_reset ? 8'h00 : 8'h04);
		repeat (40) @(posedge clock);
		chk({conv_done_flag, sample_hold}, 2'b00);
		$display("test stop %0d done", by_reset);
	endtask
	// ==================================================================
	// main sequence and watchdog
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		flag_clear = 1'b0;
		fail_count = 0;
		tests_run = 0;
		do_reset(16);
		t_regs();
		t_pins();
		t_conv(4'h0, 1'b0);
		t_conv(4'hC, 1'b0);
		t_conv(4'h9, 1'b1);
		t_stop(1'b0);
		t_stop(1'b1);
		report_and_stop();
	end
	initial begin
		#100000;
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule
